// file: hw/core_seq_pkg.sv
// shared constants and types for the core memory cycle sequencer
`default_nettype none
package core_seq_pkg;
  // store geometry
  localparam int ADDR_W = 10; // location latch width
  localparam int WORD_W = 36; // one bit per plane
  localparam int LINES = 32; // drive lines per axis
  localparam int FIELD_W = 5; // address bits per axis
  localparam int X_LSB = 0; // x field position
  localparam int Y_LSB = 5; // y field position
  localparam int SEL_W = 3; // pulse-select bits of a field
  localparam int EN_W = 2; // enable bits of a field
  localparam int GROUPS = 3; // digit stage groups
  localparam int GROUP_LSB [GROUPS] = '{0, 15, 30}; // first stage of each group
  localparam int GROUP_WIDTH [GROUPS] = '{15, 15, 6}; // stages per group
  // phase counter values
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_IDLE = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_START = 3'h1; // loaded by phase zero
  localparam logic [PHASE_W-1:0] PHASE_READ_PULSE = 3'h2;
  localparam logic [PHASE_W-1:0] PHASE_SWITCH = 3'h3;
  localparam logic [PHASE_W-1:0] PHASE_WRITE_PULSE = 3'h4;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h5;
  // write group masks (bit per group)
  localparam logic [GROUPS-1:0] MASK_NONE = 3'h0;
  localparam logic [GROUPS-1:0] MASK_LOW = 3'h1;
  localparam logic [GROUPS-1:0] MASK_MIDDLE = 3'h2;
  localparam logic [GROUPS-1:0] MASK_ALL = 3'h7;
  // timing, ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLOCK_PULSE_NS = 2000; // core clock pulse spacing
  localparam int DELAY3_NS = 1000; // delayed phase 3, mid-way to phase 4
  localparam int DELAY5_NS = 2000; // delayed phase 5
  localparam int CLOCK_PULSE_CYC = (CLOCK_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : CLOCK_PULSE_NS / CLK_PERIOD_NS;
  localparam int DELAY3_CYC = (DELAY3_NS / CLK_PERIOD_NS < 1) ? 1 : DELAY3_NS / CLK_PERIOD_NS;
  localparam int DELAY5_CYC = (DELAY5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12; // timing counter width
  // request kinds
  typedef enum {OP_READ, OP_FULL_WRITE, OP_LOW_WRITE, OP_MIDDLE_WRITE} op_t;
endpackage
`default_nettype wire

// file: hw/digit_ctrl_if.sv
// control strobes from the sequencer to the digit stage groups
`default_nettype none
interface digit_ctrl_if;
  logic clear_holding; // phase 1: clear every stage
  logic read_window; // read pulse active, sense is valid
  logic [core_seq_pkg::GROUPS-1:0] write_pulse; // group write pulses
  logic [core_seq_pkg::GROUPS-1:0] restore_pulse; // group restore pulses
  logic read_transfer; // read transfer to the exchange register
  logic inhibit_enable; // inhibit/disturb enable
  logic flux_standardize; // final portion of inhibit/disturb
  modport sequencer (output clear_holding, read_window, write_pulse, restore_pulse, read_transfer,
    inhibit_enable, flux_standardize);
  modport stage (input clear_holding, read_window, write_pulse, restore_pulse, read_transfer,
    inhibit_enable, flux_standardize);
endinterface
`default_nettype wire

// file: hw/digit_stage_group.sv
// one group of digit holding stages with their plane inhibit drives
`default_nettype none
module digit_stage_group #(
  parameter int WIDTH = 15,
  parameter int GROUP = 0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  digit_ctrl_if.stage ctl,
  input wire logic [WIDTH-1:0] exchange_in,
  input wire logic [WIDTH-1:0] sense_in,
  output logic [WIDTH-1:0] holding,
  output logic [WIDTH-1:0] exchange_set,
  output logic [WIDTH-1:0] inhibit_line
);
  logic [WIDTH-1:0] holding_reg, holding_next; // digit holding stages
  logic [WIDTH-1:0] sensed_reg, sensed_next; // ones seen on sense during read pulse
  logic [WIDTH-1:0] xfer_reg; // exchange set pulses
  logic [WIDTH-1:0] inhibit_reg; // plane inhibit drives
  wire logic group_write = ctl.write_pulse[GROUP]; // this group is written
  wire logic group_restore = ctl.restore_pulse[GROUP]; // this group is restored
  wire logic [WIDTH-1:0] inhibit_next; // next inhibit level

  // holding stage next value
  always_comb begin
    holding_next = holding_reg;
    if (ctl.clear_holding) begin
      holding_next = '0;
    end else if (group_write) begin
      holding_next = holding_reg | exchange_in;
    end else if (group_restore) begin
      holding_next = holding_reg | sensed_reg;
    end
  end

  // sense capture, only while the read pulse drives the cores
  always_comb begin
    sensed_next = sensed_reg;
    if (ctl.clear_holding) begin
      sensed_next = '0;
    end else if (ctl.read_window) begin
      sensed_next = sensed_reg | sense_in;
    end
  end

  // zero in a stage, or the flux-standardize tail, drives inhibit
  assign inhibit_next = ctl.inhibit_enable ? (~holding_next | {WIDTH{ctl.flux_standardize}}) : '0;

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      holding_reg <= '0;
      sensed_reg <= '0;
      xfer_reg <= '0;
      inhibit_reg <= '0;
    end else begin
      holding_reg <= holding_next;
      sensed_reg <= sensed_next;
      xfer_reg <= ctl.read_transfer ? sensed_reg : '0;
      inhibit_reg <= inhibit_next;
    end
  end

  assign holding = holding_reg;
  assign exchange_set = xfer_reg;
  assign inhibit_line = inhibit_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_WRITE_SETS_ONES: assert property (group_write && !ctl.clear_holding |=> holding_reg == $past(exchange_in))
    else $error("written stage does not follow exchange bit");
  AST_TRANSFER_ONLY_READ: assert property (xfer_reg != '0 |-> $past(ctl.read_transfer))
    else $error("exchange set without read transfer");
  AST_FLUX_ALL_PLANES: assert property (ctl.inhibit_enable && ctl.flux_standardize |=> inhibit_reg == '1)
    else $error("flux standardize missed a plane");
  AST_ZERO_INHIBITS: assert property (ctl.inhibit_enable && !group_write && !group_restore && !ctl.clear_holding
    |=> inhibit_reg == (~holding_reg | {WIDTH{$past(ctl.flux_standardize)}}))
    else $error("inhibit does not track held zeros");
endmodule
`default_nettype wire

// file: hw/core_memory_cycle_sequencer.sv
// core store cycle sequencer: phase counter, access control and line decode
// Operation
// - upper five address bits pick one Y line
// - ten-bit address picks one of 1024 words
// - write step drives same lines, opposite polarity
// - 36 digit stages hold write or restore data
// - first phase clears all holding stages
// - partial writes cover 0-14 or 15-29 only
// - unwritten stages restore, no exchange transfer
// - write pulse sets stage when exchange bit one
// - held zero gates inhibit, core stays zero
// - written groups get write, others restore pulse
// - sensed one sets exchange bit and holding
// - no sense leaves zero, inhibit holds core
// - flux-standardize drives every inhibit line
// - any request while idle gives phase zero, loads 001
// - each clock pulse issues phase, advances count
// - phase five clears counter, then idle
// - delayed phase three and phase five pulses
// - low five bits pick one X line
// - read and write enables and pulses timing
// - inhibit and flux spans end at delayed five
// - write pulses at three, restore delayed three
`default_nettype none
module core_memory_cycle_sequencer #(
  parameter int CLOCK_PULSE_CYC = core_seq_pkg::CLOCK_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic read_request,
  input wire logic full_write_request,
  input wire logic low_partial_write_request,
  input wire logic middle_partial_write_request,
  input wire logic [core_seq_pkg::ADDR_W-1:0] storage_location_source,
  input wire logic [core_seq_pkg::WORD_W-1:0] exchange_in,
  input wire logic [core_seq_pkg::WORD_W-1:0] sense_in,
  output logic phase_zero_pulse,
  output logic [core_seq_pkg::PHASE_LAST:core_seq_pkg::PHASE_START] phase_pulse,
  output logic delayed_phase3_pulse,
  output logic delayed_phase5_pulse,
  output logic busy,
  output logic [core_seq_pkg::PHASE_W-1:0] phase_counter,
  output logic [core_seq_pkg::ADDR_W-1:0] core_location_latch,
  output logic [core_seq_pkg::LINES-1:0] read_x_line,
  output logic [core_seq_pkg::LINES-1:0] read_y_line,
  output logic [core_seq_pkg::LINES-1:0] write_x_line,
  output logic [core_seq_pkg::LINES-1:0] write_y_line,
  output logic [core_seq_pkg::WORD_W-1:0] digit_holding_register,
  output logic [core_seq_pkg::WORD_W-1:0] exchange_set,
  output logic [core_seq_pkg::WORD_W-1:0] inhibit_line,
  output logic read_transfer_pulse
);
  localparam int CW = core_seq_pkg::CNT_W;
  localparam int GN = core_seq_pkg::GROUPS;
  localparam int LN = core_seq_pkg::LINES;
  localparam int AST_D5 = core_seq_pkg::DELAY5_CYC; // delayed phase 5 distance
  localparam int AST_D3 = core_seq_pkg::DELAY3_CYC; // delayed phase 3 distance

  // core clock pulse divider
  logic [CW-1:0] divider_reg, divider_next;
  wire logic clock_pulse_en = (divider_reg == '0); // one-cycle core clock pulse

  // phase counter and cycle kind
  logic [core_seq_pkg::PHASE_W-1:0] phase_counter_reg, phase_counter_next;
  logic [GN-1:0] write_mask_reg; // groups written this cycle
  logic read_op_reg; // cycle is a read
  logic [core_seq_pkg::ADDR_W-1:0] location_reg; // core location latch
  core_seq_pkg::op_t op_sel; // request chosen this cycle
  logic [GN-1:0] op_mask; // its write groups

  // access control enables
  logic read_enable_reg, write_enable_reg; // step enables
  logic read_pulse_reg, write_pulse_reg; // short drive pulses
  logic inhibit_enable_reg, flux_reg; // digit drive spans
  logic [CW-1:0] delay3_reg, delay5_reg; // delay lines, zero when idle
  logic [LN-1:0] read_x_reg, read_y_reg, write_x_reg, write_y_reg; // registered drive lines

  digit_ctrl_if ctl ();

  // x/y decoder: two enable bits pick a bank of eight, three select bits a line
  function automatic logic [LN-1:0] decode_lines(input logic [core_seq_pkg::FIELD_W-1:0] field,
                                                 input logic enable, input logic pulse);
    logic [3:0] bank;
    logic [7:0] sel;
    logic [LN-1:0] lines;
    bank = enable ? (4'h1 << field[core_seq_pkg::FIELD_W-1 -: core_seq_pkg::EN_W]) : 4'h0;
    sel = pulse ? (8'h01 << field[core_seq_pkg::SEL_W-1:0]) : 8'h00;
    lines = '0;
    for (int i = 0; i < LN; i++) begin
      lines[i] = bank[i / 8] & sel[i % 8];
    end
    return lines;
  endfunction

  // request acceptance
  wire logic any_request = read_request | full_write_request | low_partial_write_request |
                           middle_partial_write_request;
  wire logic idle = (phase_counter_reg == core_seq_pkg::PHASE_IDLE) && !inhibit_enable_reg && (delay5_reg == '0);
  wire logic accept = any_request & idle;
  wire logic phase_step = clock_pulse_en && (phase_counter_reg != core_seq_pkg::PHASE_IDLE);
  wire logic p1 = phase_step && (phase_counter_reg == core_seq_pkg::PHASE_START);
  wire logic p2 = phase_step && (phase_counter_reg == core_seq_pkg::PHASE_READ_PULSE);
  wire logic p3 = phase_step && (phase_counter_reg == core_seq_pkg::PHASE_SWITCH);
  wire logic p4 = phase_step && (phase_counter_reg == core_seq_pkg::PHASE_WRITE_PULSE);
  wire logic p5 = phase_step && (phase_counter_reg == core_seq_pkg::PHASE_LAST);
  wire logic dp3 = (delay3_reg == CW'(1));
  wire logic dp5 = (delay5_reg == CW'(1));

  // request priority: read, full, low, middle
  always_comb begin
    op_sel = core_seq_pkg::OP_MIDDLE_WRITE;
    if (read_request) begin
      op_sel = core_seq_pkg::OP_READ;
    end else if (full_write_request) begin
      op_sel = core_seq_pkg::OP_FULL_WRITE;
    end else if (low_partial_write_request) begin
      op_sel = core_seq_pkg::OP_LOW_WRITE;
    end
  end

  // write group mask for the chosen request
  always_comb begin
    case (op_sel)
      core_seq_pkg::OP_READ: op_mask = core_seq_pkg::MASK_NONE;
      core_seq_pkg::OP_FULL_WRITE: op_mask = core_seq_pkg::MASK_ALL;
      core_seq_pkg::OP_LOW_WRITE: op_mask = core_seq_pkg::MASK_LOW;
      core_seq_pkg::OP_MIDDLE_WRITE: op_mask = core_seq_pkg::MASK_MIDDLE;
      default: op_mask = core_seq_pkg::MASK_NONE;
    endcase
  end

  // divider next value
  always_comb begin
    divider_next = clock_pulse_en ? CW'(CLOCK_PULSE_CYC - 1) : divider_reg - CW'(1);
  end

  // phase counter next value
  always_comb begin
    phase_counter_next = phase_counter_reg;
    if (accept) begin
      phase_counter_next = core_seq_pkg::PHASE_START;
    end else if (p5) begin
      phase_counter_next = core_seq_pkg::PHASE_IDLE;
    end else if (phase_step) begin
      phase_counter_next = phase_counter_reg + core_seq_pkg::PHASE_W'(1);
    end
  end

  // divider and phase counter
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      divider_reg <= '0;
      phase_counter_reg <= core_seq_pkg::PHASE_IDLE;
    end else begin
      divider_reg <= divider_next;
      phase_counter_reg <= phase_counter_next;
    end
  end

  // cycle kind and address latch, taken with phase zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_mask_reg <= core_seq_pkg::MASK_NONE;
      read_op_reg <= 1'b0;
      location_reg <= '0;
    end else if (accept) begin
      write_mask_reg <= op_mask;
      read_op_reg <= (op_sel == core_seq_pkg::OP_READ);
      location_reg <= storage_location_source;
    end
  end

  // step enables and drive pulses
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      read_enable_reg <= 1'b0;
      write_enable_reg <= 1'b0;
      read_pulse_reg <= 1'b0;
      write_pulse_reg <= 1'b0;
    end else begin
      read_enable_reg <= accept | (read_enable_reg & ~p3);
      write_enable_reg <= p3 | (write_enable_reg & ~p5);
      read_pulse_reg <= p2 | (read_pulse_reg & ~p3);
      write_pulse_reg <= p4 | (write_pulse_reg & ~p5);
    end
  end

  // inhibit/disturb span and its flux-standardize tail
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      inhibit_enable_reg <= 1'b0;
      flux_reg <= 1'b0;
    end else begin
      inhibit_enable_reg <= p3 | (inhibit_enable_reg & ~dp5);
      flux_reg <= p5 | (flux_reg & ~dp5);
    end
  end

  // delay lines for delayed phase 3 and phase 5
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      delay3_reg <= '0;
      delay5_reg <= '0;
    end else begin
      delay3_reg <= p3 ? CW'(core_seq_pkg::DELAY3_CYC) : (delay3_reg != '0 ? delay3_reg - CW'(1) : '0);
      delay5_reg <= p5 ? CW'(core_seq_pkg::DELAY5_CYC) : (delay5_reg != '0 ? delay5_reg - CW'(1) : '0);
    end
  end

  // drive line decode; clear step one polarity, write step the other
  wire logic [core_seq_pkg::FIELD_W-1:0] x_field = location_reg[core_seq_pkg::X_LSB +: core_seq_pkg::FIELD_W];
  wire logic [core_seq_pkg::FIELD_W-1:0] y_field = location_reg[core_seq_pkg::Y_LSB +: core_seq_pkg::FIELD_W];
  wire logic [LN-1:0] read_x_next = decode_lines(x_field, read_enable_reg, read_pulse_reg);
  wire logic [LN-1:0] read_y_next = decode_lines(y_field, read_enable_reg, read_pulse_reg);
  wire logic [LN-1:0] write_x_next = decode_lines(x_field, write_enable_reg, write_pulse_reg);
  wire logic [LN-1:0] write_y_next = decode_lines(y_field, write_enable_reg, write_pulse_reg);

  // registered drive lines
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      read_x_reg <= '0;
      read_y_reg <= '0;
      write_x_reg <= '0;
      write_y_reg <= '0;
    end else begin
      read_x_reg <= read_x_next;
      read_y_reg <= read_y_next;
      write_x_reg <= write_x_next;
      write_y_reg <= write_y_next;
    end
  end

  // digit control strobes
  assign ctl.clear_holding = p1;
  assign ctl.read_window = read_pulse_reg;
  assign ctl.write_pulse = p3 ? write_mask_reg : core_seq_pkg::MASK_NONE;
  assign ctl.restore_pulse = dp3 ? ~write_mask_reg : core_seq_pkg::MASK_NONE;
  assign ctl.read_transfer = dp3 & read_op_reg;
  assign ctl.inhibit_enable = inhibit_enable_reg;
  assign ctl.flux_standardize = flux_reg;

  // one stage group per pulse group
  for (genvar g = 0; g < GN; g++) begin : gen_group
    digit_stage_group #(
      .WIDTH(core_seq_pkg::GROUP_WIDTH[g]),
      .GROUP(g)
    ) u_group (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .ctl(ctl),
      .exchange_in(exchange_in[core_seq_pkg::GROUP_LSB[g] +: core_seq_pkg::GROUP_WIDTH[g]]),
      .sense_in(sense_in[core_seq_pkg::GROUP_LSB[g] +: core_seq_pkg::GROUP_WIDTH[g]]),
      .holding(digit_holding_register[core_seq_pkg::GROUP_LSB[g] +: core_seq_pkg::GROUP_WIDTH[g]]),
      .exchange_set(exchange_set[core_seq_pkg::GROUP_LSB[g] +: core_seq_pkg::GROUP_WIDTH[g]]),
      .inhibit_line(inhibit_line[core_seq_pkg::GROUP_LSB[g] +: core_seq_pkg::GROUP_WIDTH[g]])
    );
  end

  // outputs
  assign phase_zero_pulse = accept;
  assign phase_pulse = {p5, p4, p3, p2, p1};
  assign delayed_phase3_pulse = dp3;
  assign delayed_phase5_pulse = dp5;
  assign busy = !idle;
  assign phase_counter = phase_counter_reg;
  assign core_location_latch = location_reg;
  assign read_x_line = read_x_reg;
  assign read_y_line = read_y_reg;
  assign write_x_line = write_x_reg;
  assign write_y_line = write_y_reg;
  assign read_transfer_pulse = ctl.read_transfer;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence seq_start;
    accept;
  endsequence
  sequence seq_last;
    p5;
  endsequence

  AST_PHASE_ZERO_LOADS: assert property (seq_start |=> phase_counter_reg == core_seq_pkg::PHASE_START)
    else $error("phase zero did not load 001");
  AST_PHASE_ADVANCES: assert property (phase_step && !p5 |=> phase_counter_reg == $past(phase_counter_reg) + 3'h1)
    else $error("phase count did not advance");
  AST_PHASE_FIVE_IDLE: assert property (seq_last |=> phase_counter_reg == core_seq_pkg::PHASE_IDLE ##1 !phase_step)
    else $error("phase five did not stop the counter");
  AST_DELAYED_FIVE: assert property (seq_last |-> ##[AST_D5:AST_D5] dp5)
    else $error("delayed phase five mistimed");
  AST_DELAYED_THREE: assert property (p3 |-> ##[AST_D3:AST_D3] (dp3 && phase_counter_reg == core_seq_pkg::PHASE_WRITE_PULSE))
    else $error("delayed phase three not between three and four");
  AST_X_DECODE: assert property (read_x_reg != '0 |->
    read_x_reg == (LN'(1) << location_reg[core_seq_pkg::X_LSB +: core_seq_pkg::FIELD_W]))
    else $error("x line does not match address");
  AST_Y_DECODE: assert property (read_y_reg != '0 |->
    read_y_reg == (LN'(1) << location_reg[core_seq_pkg::Y_LSB +: core_seq_pkg::FIELD_W]))
    else $error("y line does not match address");
  AST_WRITE_STEP_ONLY: assert property (write_x_reg != '0 |-> read_x_reg == '0 && $past(write_enable_reg))
    else $error("write drive outside write step");
  AST_LINES_QUIET_IDLE: assert property (idle |-> ##1 (read_x_reg | read_y_reg | write_x_reg | write_y_reg) == '0)
    else $error("drive line active while idle");
  AST_CLEAR_HOLDING: assert property (p1 |=> digit_holding_register == '0)
    else $error("phase one did not clear holding stages");
  AST_READ_ENABLE_SPAN: assert property (p3 |=> !read_enable_reg && write_enable_reg && inhibit_enable_reg)
    else $error("phase three did not switch steps");
endmodule
`default_nettype wire

// file: bench/seq_partner.sv
// far-side model: exchange register and core planes with sense amplifiers
`default_nettype none
module seq_partner (
  input wire logic clk_sys,
  input wire logic load,
  input wire logic [35:0] load_val,
  input wire logic [5:1] phase_pulse,
  input wire logic [9:0] core_location_latch,
  input wire logic [31:0] write_x_line,
  input wire logic [31:0] write_y_line,
  input wire logic [35:0] inhibit_line,
  input wire logic [35:0] exchange_set,
  output logic [35:0] exchange_reg,
  output logic [35:0] sense_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] plane_mem [1024]; // one word per location
  logic [35:0] noise_reg = 36'h5a5a5a5a5; // sense pattern outside the read pulse
  logic window_reg = 1'b0; // read pulse span
  // index of the driven line
  function automatic logic [4:0] line_idx(input logic [31:0] v);
    line_idx = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) line_idx = i[4:0];
    end
  endfunction
  // cores start cleared
  initial begin
    foreach (plane_mem[i]) plane_mem[i] = 36'h0;
  end
  // sense is only meaningful while read current flows
  assign sense_in = (phase_pulse[2] || window_reg) ? plane_mem[core_location_latch] : noise_reg;
  // planes, exchange register and idle pattern
  always @(posedge clk_sys) begin
    noise_reg <= ~noise_reg;
    if (phase_pulse[1]) window_reg <= 1'b0; // a cut cycle must not leave the window open
    if (phase_pulse[2]) window_reg <= 1'b1;
    if (phase_pulse[3]) window_reg <= 1'b0;
    // cores without inhibit go to one under write current
    if (write_x_line != 32'h0) plane_mem[{line_idx(write_y_line), line_idx(write_x_line)}] <= ~inhibit_line;
    if (load) exchange_reg <= load_val;
    else exchange_reg <= exchange_reg | exchange_set;
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the core memory cycle sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 400; // clock pulse spacing in cycles
  typedef struct {logic [1:0] op; logic [9:0] addr; logic [35:0] xin; logic [35:0] xout; logic [35:0] word;} row_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] req = 4'h0; // read, full, low, middle
  logic [9:0] addr = 10'h0;
  logic load = 1'b0;
  logic [35:0] load_val = 36'h0;
  logic [35:0] exchange_reg, sense_in, digit_holding_register, exchange_set, inhibit_line;
  logic [5:1] phase_pulse;
  logic phase_zero_pulse, delayed_phase3_pulse, delayed_phase5_pulse, busy, read_transfer_pulse;
  logic [2:0] phase_counter;
  logic [9:0] core_location_latch;
  logic [31:0] read_x_line, read_y_line, write_x_line, write_y_line, orx, ory, owx, owy;
  logic flux_seen, clr_seen; // flux span and phase-one clear observed
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_p0, n_rtp, t1, t3, t5, td3, td5; // per-cycle counts and pulse times
  // op, address, exchange in, exchange after, holding after
  row_t rows [8] = '{'{2'h1, 10'h3ff, 36'h9a5c30f17, 36'h9a5c30f17, 36'h9a5c30f17},
    '{2'h0, 10'h3ff, 36'h0, 36'h9a5c30f17, 36'h9a5c30f17},
    '{2'h2, 10'h3ff, 36'hfffffffff, 36'hfffffffff, 36'h9a5c37fff},
    '{2'h0, 10'h3ff, 36'h0, 36'h9a5c37fff, 36'h9a5c37fff},
    '{2'h3, 10'h3ff, 36'h0, 36'h0, 36'h980007fff},
    '{2'h0, 10'h3ff, 36'h0, 36'h980007fff, 36'h980007fff},
    '{2'h1, 10'h2b5, 36'ha55550001, 36'ha55550001, 36'ha55550001},
    '{2'h0, 10'h2b5, 36'h0, 36'ha55550001, 36'ha55550001}};
  core_memory_cycle_sequencer #(.CLOCK_PULSE_CYC(T)) dut (.clk_sys, .reset_n, .read_request(req[0]),
    .full_write_request(req[1]), .low_partial_write_request(req[2]), .middle_partial_write_request(req[3]),
    .storage_location_source(addr), .exchange_in(exchange_reg), .sense_in, .phase_zero_pulse, .phase_pulse,
    .delayed_phase3_pulse, .delayed_phase5_pulse, .busy, .phase_counter, .core_location_latch, .read_x_line,
    .read_y_line, .write_x_line, .write_y_line, .digit_holding_register, .exchange_set, .inhibit_line,
    .read_transfer_pulse);
  seq_partner partner (.clk_sys, .load, .load_val, .phase_pulse, .core_location_latch, .write_x_line,
    .write_y_line, .inhibit_line, .exchange_set, .exchange_reg, .sense_in);
  // clock
  always #2.5 clk_sys = ~clk_sys;
  // observation of the running core cycle
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (phase_zero_pulse) n_p0 <= n_p0 + 1;
    if (read_transfer_pulse) n_rtp <= n_rtp + 1;
    if (phase_pulse[1]) t1 <= cyc;
    if (phase_pulse[3]) t3 <= cyc;
    if (phase_pulse[5]) t5 <= cyc;
    if (delayed_phase3_pulse) td3 <= cyc;
    if (delayed_phase5_pulse) td5 <= cyc;
    if (t1 == cyc - 1 && digit_holding_register === 36'h0) clr_seen <= 1'b1;
    if (busy && phase_counter == 3'h0 && inhibit_line === '1) flux_seen <= 1'b1;
    orx <= orx | read_x_line;
    ory <= ory | read_y_line;
    owx <= owx | write_x_line;
    owy <= owy | write_y_line;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // outputs quiet while idle
  task automatic idle_chk();
    check(36'({busy, phase_counter, read_transfer_pulse, phase_pulse}), 36'h0);
    check(digit_holding_register | inhibit_line | exchange_set, 36'h0);
  endtask
  // one whole core cycle; extra requests go with it and again while busy
  task automatic do_op(input row_t r, input logic [3:0] extra);
    int w;
    @(negedge clk_sys);
    load = 1'b1;
    load_val = r.xin;
    addr = r.addr;
    {n_p0, n_rtp, orx, ory, owx, owy, flux_seen, clr_seen} = 0;
    @(negedge clk_sys);
    load = 1'b0;
    req = (4'h1 << r.op) | extra;
    #1 check(36'(phase_zero_pulse), 36'h1);
    @(negedge clk_sys);
    req = 4'h0;
    repeat (100) @(negedge clk_sys);
    req = extra;
    @(negedge clk_sys);
    req = 4'h0;
    w = 0;
    while (busy !== 1'b0 && w < 8 * T) begin
      @(negedge clk_sys);
      w++;
    end
    check(exchange_reg, r.xout);
    check(digit_holding_register, r.word);
    check(36'(core_location_latch), 36'(r.addr));
    check(36'(orx), 36'(32'h1 << r.addr[4:0]));
    check(36'(ory), 36'(32'h1 << r.addr[9:5]));
    check(36'(owx), 36'(32'h1 << r.addr[4:0]));
    check(36'(owy), 36'(32'h1 << r.addr[9:5]));
    check(36'(n_p0), 36'h1);
    check(36'(n_rtp), 36'(r.op == 2'h0));
    check(36'(t5 - t1), 36'(4 * T));
    check(36'(td3 - t3), 36'(core_seq_pkg::DELAY3_CYC));
    check(36'(td5 - t5), 36'(core_seq_pkg::DELAY5_CYC));
    check(36'({clr_seen, flux_seen}), 36'h3);
    check(36'(phase_counter), 36'h0);
  endtask
  // reset, table, then awkward cases
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    #1 idle_chk();
    foreach (rows[i]) begin
      do_op(rows[i], 4'h0);
    end
    do_op('{2'h0, 10'h3ff, 36'h0, 36'h980007fff, 36'h980007fff}, 4'h6);
    @(negedge clk_sys);
    req = 4'h2;
    @(negedge clk_sys);
    req = 4'h0;
    repeat (2 * T + 50) @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    #1 idle_chk();
    do_op(rows[5], 4'h0);
    test_done();
  end
  // hang guard, well past eleven cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
